// >>> design/port_c_defines.svh
// Register offsets, field positions, reset values and masks of the upper port C pin multiplexer.
`ifndef PORT_C_DEFINES_SVH
`define PORT_C_DEFINES_SVH

`define PC_ADDR_W            8
`define PC_OFF_ANALOG_SEL    8'h00
`define PC_OFF_OUT_LATCH     8'h04
`define PC_OFF_PIN_LEVEL     8'h08
`define PC_OFF_SLEW_RATE     8'h0C
`define PC_OFF_DIRECTION     8'h10
`define PC_OFF_CFG_PIN_MAP   8'h14

`define PC_MASK_ANALOG_SEL   8'hFC
`define PC_MASK_SLEW_RATE    8'h1F
`define PC_MASK_CFG_PIN_MAP  8'hBF
`define PC_MASK_PIN_LEVEL    8'hE0

`define PC_RST_ANALOG_SEL    8'hFC
`define PC_RST_OUT_LATCH     8'h00
`define PC_RST_SLEW_RATE     8'h1F
`define PC_RST_DIRECTION     8'hFF
`define PC_RST_CFG_PIN_MAP   8'hBF

`define PC_CFG_PWM2B_SEL     5
`define PC_CFG_T3CLK_SEL     4
`define PC_CFG_CMP3_SEL      2
`define PC_CFG_CMP2_SEL      0
`define PC_SLEW_PORT_C       2

`define PC_PIN5              5
`define PC_PIN6              6
`define PC_PIN7              7
`define PC_SYNC_STAGES       2

`endif

// >>> design/port_c_pkg.sv
// Types shared by the upper port C pin multiplexer.
package port_c_pkg;

    typedef logic [7:0] byte_t;

    typedef enum logic [3:0] {
        SRC_HIGH_Z  = 4'h0,
        SRC_LATCH   = 4'h1,
        SRC_SPI_DO  = 4'h2,
        SRC_PWM3_A  = 4'h3,
        SRC_CMP3    = 4'h4,
        SRC_TX      = 4'h5,
        SRC_SER_CLK = 4'h6,
        SRC_SER_DAT = 4'h7,
        SRC_PWM3_B  = 4'h8
    } pin_src_t;

endpackage

// >>> design/pin_sync.sv
// Two-stage synchroniser for the port pin inputs.
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
    parameter int WIDTH = 3
) (
    // Clock and reset.
    input  wire logic             clk,
    input  wire logic             resetn,
    // Asynchronous input and synchronised output.
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sync_state_t;

    sync_state_t st_r;
    sync_state_t st_nxt;

    always_comb begin
        st_nxt        = st_r;
        st_nxt.meta   = async_in;
        st_nxt.stable = st_r.meta;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sync_out = st_r.stable;

endmodule // pin_sync

`default_nettype wire

// >>> design/port_c_upper_pin_mux.sv
// Pin multiplexer for port C pins 5 to 7 with its APB register file.
//
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "port_c_defines.svh"

// Notes on behaviour
// - Direction 0 with no peripheral owning the pin drives the latch bit.
// - Pin level is sampled; digital input reads zero while analog select is set.
// - Pin 5 carries the SPI data output when its direction is 0.
// - Pins 6 and 7 carry PWM3 outputs A and B with direction 0.
// - Pin 6 outputs compare channel three, or feeds its capture with direction 1.
// - Pin 6 carries serial transmit data when the transmitter is active, direction 1.
// - Sync mode: pin 6 drives serial clock as master, receives it as slave.
// - Pin 7 feeds the serial receiver when direction 1 and analog select 0.
// - Sync mode: pin 7 is the bidirectional serial data line, direction 1.
// - Pin-map bits at 1 keep their functions on default pins.
// - Pin-map bits at 0 move functions away; compare three leaves this port.
// - Unimplemented register bits read back as zero.
// - Competing enabled outputs give the pin to the highest-priority peripheral.
// - Digital outputs still drive a pin whose analog select is set.
module port_c_upper_pin_mux
    import port_c_pkg::*;
(
    // Clock and reset.
    input  wire logic                    clk,
    input  wire logic                    resetn,
    // APB slave.
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [`PC_ADDR_W-1:0]   paddr,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    // Package pins 5 to 7, index 0 is pin 5.
    input  wire logic [2:0]              pin_in,
    output logic      [2:0]              pin_out,
    output logic      [2:0]              pin_oe_n,
    // Synchronous serial port one.
    input  wire logic                    spi_one_enable,
    input  wire logic                    spi_one_data_out,
    // Third enhanced capture/compare/PWM unit.
    input  wire logic                    pwm3_a_enable,
    input  wire logic                    pwm3_output_a,
    input  wire logic                    pwm3_b_enable,
    input  wire logic                    pwm3_output_b,
    input  wire logic                    compare3_enable,
    input  wire logic                    compare_channel_three,
    output logic                         compare3_capture_in,
    // Universal serial unit.
    input  wire logic                    serial_tx_active,
    input  wire logic                    serial_tx_one,
    input  wire logic                    serial_sync_mode,
    input  wire logic                    serial_sync_master,
    input  wire logic                    serial_clk_one,
    input  wire logic                    serial_dat_drive,
    input  wire logic                    serial_dat_one,
    output logic                         serial_rx_one,
    output logic                         serial_clk_one_in,
    output logic                         serial_dat_one_in,
    // Pin-map selects for functions routed elsewhere, and slew control.
    output logic                         pwm2b_pin_select,
    output logic                         timer3_clk_pin_select,
    output logic                         compare3_pin_select,
    output logic                         compare2_pin_select,
    output logic                         slew_limit_c
);

    typedef struct packed {
        byte_t       analog_select_c;
        byte_t       output_latch_c;
        byte_t       slew_rate_control;
        byte_t       direction_c;
        byte_t       config_pin_map;
        logic [2:0]  pin_out;
        logic [2:0]  pin_oe_n;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic        capture_in;
        logic        rx_in;
        logic        clk_in;
        logic        dat_in;
        logic        pwm2b_sel;
        logic        t3clk_sel;
        logic        cmp3_sel;
        logic        cmp2_sel;
        logic        slew_limit;
    } mux_state_t;

    mux_state_t st_r;
    mux_state_t st_nxt;

    logic [2:0] pin_sync_w;
    byte_t      pin_level_w;
    pin_src_t   src5;
    pin_src_t   src6;
    pin_src_t   src7;

    // Address decode for the error answer; reads decode the offsets on their own.
    function automatic logic addr_mapped(input logic [`PC_ADDR_W-1:0] a);
        logic hit;
        hit = 1'b0;
        if (a == `PC_OFF_ANALOG_SEL) begin
            hit = 1'b1;
        end else if (a == `PC_OFF_OUT_LATCH) begin
            hit = 1'b1;
        end else if (a == `PC_OFF_PIN_LEVEL) begin
            hit = 1'b1;
        end else if (a == `PC_OFF_SLEW_RATE) begin
            hit = 1'b1;
        end else if (a == `PC_OFF_DIRECTION) begin
            hit = 1'b1;
        end else if (a == `PC_OFF_CFG_PIN_MAP) begin
            hit = 1'b1;
        end
        return hit;
    endfunction

    // Resolves a chosen source into the pin's drive value.
    function automatic logic src_value(input pin_src_t s, input logic latch);
        logic v;
        v = 1'b0;
        case (s)
            SRC_LATCH:   v = latch;
            SRC_SPI_DO:  v = spi_one_data_out;
            SRC_PWM3_A:  v = pwm3_output_a;
            SRC_CMP3:    v = compare_channel_three;
            SRC_TX:      v = serial_tx_one;
            SRC_SER_CLK: v = serial_clk_one;
            SRC_SER_DAT: v = serial_dat_one;
            SRC_PWM3_B:  v = pwm3_output_b;
            default:     v = 1'b0;
        endcase
        return v;
    endfunction

    pin_sync #(
        .WIDTH    (3)
    ) u_pin_sync (
        .clk      (clk),
        .resetn   (resetn),
        .async_in (pin_in),
        .sync_out (pin_sync_w)
    );

    // Digital input path is cut to zero on pins in analog mode.
    always_comb begin
        pin_level_w = '0;
        pin_level_w[`PC_PIN7:`PC_PIN5] = pin_sync_w & ~st_r.analog_select_c[`PC_PIN7:`PC_PIN5];
    end

    // Output source selection, highest priority first, analog select ignored.
    always_comb begin
        src5 = SRC_HIGH_Z;
        src6 = SRC_HIGH_Z;
        src7 = SRC_HIGH_Z;
        if (!st_r.direction_c[`PC_PIN5]) begin
            if (spi_one_enable) begin
                src5 = SRC_SPI_DO;
            end else begin
                src5 = SRC_LATCH;
            end
        end
        if (st_r.direction_c[`PC_PIN6]) begin
            if (serial_tx_active) begin
                src6 = SRC_TX;
            end else if (serial_sync_mode && serial_sync_master) begin
                src6 = SRC_SER_CLK;
            end
        end else if (st_r.cmp3_sel && pwm3_a_enable) begin
            src6 = SRC_PWM3_A;
        end else if (st_r.cmp3_sel && compare3_enable) begin
            src6 = SRC_CMP3;
        end else begin
            src6 = SRC_LATCH;
        end
        if (st_r.direction_c[`PC_PIN7]) begin
            if (serial_sync_mode && serial_dat_drive) begin
                src7 = SRC_SER_DAT;
            end
        end else if (pwm3_b_enable) begin
            src7 = SRC_PWM3_B;
        end else begin
            src7 = SRC_LATCH;
        end
    end

    always_comb begin
        st_nxt = st_r;

        // Pin drivers; the enable is low while the pin is driven.
        st_nxt.pin_out[0]  = src_value(src5, st_r.output_latch_c[`PC_PIN5]);
        st_nxt.pin_out[1]  = src_value(src6, st_r.output_latch_c[`PC_PIN6]);
        st_nxt.pin_out[2]  = src_value(src7, st_r.output_latch_c[`PC_PIN7]);
        st_nxt.pin_oe_n[0] = (src5 == SRC_HIGH_Z);
        st_nxt.pin_oe_n[1] = (src6 == SRC_HIGH_Z);
        st_nxt.pin_oe_n[2] = (src7 == SRC_HIGH_Z);

        // Inputs handed to the peripherals, all taken after the synchroniser.
        st_nxt.capture_in = st_r.cmp3_sel && st_r.direction_c[`PC_PIN6]
                            && pin_level_w[`PC_PIN6];
        st_nxt.rx_in      = st_r.direction_c[`PC_PIN7] && pin_level_w[`PC_PIN7];
        st_nxt.clk_in     = serial_sync_mode && !serial_sync_master
                            && st_r.direction_c[`PC_PIN6] && pin_level_w[`PC_PIN6];
        st_nxt.dat_in     = serial_sync_mode && st_r.direction_c[`PC_PIN7]
                            && pin_level_w[`PC_PIN7];

        // Pin-map selects follow the configuration register.
        st_nxt.pwm2b_sel  = st_r.config_pin_map[`PC_CFG_PWM2B_SEL];
        st_nxt.t3clk_sel  = st_r.config_pin_map[`PC_CFG_T3CLK_SEL];
        st_nxt.cmp3_sel   = st_r.config_pin_map[`PC_CFG_CMP3_SEL];
        st_nxt.cmp2_sel   = st_r.config_pin_map[`PC_CFG_CMP2_SEL];
        st_nxt.slew_limit = st_r.slew_rate_control[`PC_SLEW_PORT_C];

        // APB: answer is prepared in the setup cycle, so the access phase has no wait state.
        st_nxt.pready  = 1'b0;
        st_nxt.pslverr = 1'b0;
        if (psel && !penable) begin
            st_nxt.pready  = 1'b1;
            st_nxt.pslverr = !addr_mapped(paddr);
            st_nxt.prdata  = '0;
            if (!pwrite) begin
                if (paddr == `PC_OFF_ANALOG_SEL) begin
                    st_nxt.prdata[7:0] = st_r.analog_select_c & `PC_MASK_ANALOG_SEL;
                end else if (paddr == `PC_OFF_OUT_LATCH) begin
                    st_nxt.prdata[7:0] = st_r.output_latch_c;
                end else if (paddr == `PC_OFF_PIN_LEVEL) begin
                    st_nxt.prdata[7:0] = pin_level_w & `PC_MASK_PIN_LEVEL;
                end else if (paddr == `PC_OFF_SLEW_RATE) begin
                    st_nxt.prdata[7:0] = st_r.slew_rate_control & `PC_MASK_SLEW_RATE;
                end else if (paddr == `PC_OFF_DIRECTION) begin
                    st_nxt.prdata[7:0] = st_r.direction_c;
                end else if (paddr == `PC_OFF_CFG_PIN_MAP) begin
                    st_nxt.prdata[7:0] = st_r.config_pin_map & `PC_MASK_CFG_PIN_MAP;
                end
            end
        end

        // Writes take effect at the edge that completes the access phase.
        if (psel && penable && st_r.pready && pwrite) begin
            if (paddr == `PC_OFF_ANALOG_SEL) begin
                st_nxt.analog_select_c = pwdata[7:0] & `PC_MASK_ANALOG_SEL;
            end else if (paddr == `PC_OFF_OUT_LATCH) begin
                st_nxt.output_latch_c = pwdata[7:0];
            end else if (paddr == `PC_OFF_PIN_LEVEL) begin
                st_nxt.output_latch_c = pwdata[7:0];
            end else if (paddr == `PC_OFF_SLEW_RATE) begin
                st_nxt.slew_rate_control = pwdata[7:0] & `PC_MASK_SLEW_RATE;
            end else if (paddr == `PC_OFF_DIRECTION) begin
                st_nxt.direction_c = pwdata[7:0];
            end else if (paddr == `PC_OFF_CFG_PIN_MAP) begin
                st_nxt.config_pin_map = pwdata[7:0] & `PC_MASK_CFG_PIN_MAP;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_r                   <= '0;
            st_r.analog_select_c   <= `PC_RST_ANALOG_SEL;
            st_r.output_latch_c    <= `PC_RST_OUT_LATCH;
            st_r.slew_rate_control <= `PC_RST_SLEW_RATE;
            st_r.direction_c       <= `PC_RST_DIRECTION;
            st_r.config_pin_map    <= `PC_RST_CFG_PIN_MAP;
            st_r.pin_oe_n          <= 3'h7;
            st_r.pwm2b_sel         <= 1'b1;
            st_r.t3clk_sel         <= 1'b1;
            st_r.cmp3_sel          <= 1'b1;
            st_r.cmp2_sel          <= 1'b1;
            st_r.slew_limit        <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign prdata                = st_r.prdata;
    assign pready                = st_r.pready;
    assign pslverr               = st_r.pslverr;
    assign pin_out               = st_r.pin_out;
    assign pin_oe_n              = st_r.pin_oe_n;
    assign compare3_capture_in   = st_r.capture_in;
    assign serial_rx_one         = st_r.rx_in;
    assign serial_clk_one_in     = st_r.clk_in;
    assign serial_dat_one_in     = st_r.dat_in;
    assign pwm2b_pin_select      = st_r.pwm2b_sel;
    assign timer3_clk_pin_select = st_r.t3clk_sel;
    assign compare3_pin_select   = st_r.cmp3_sel;
    assign compare2_pin_select   = st_r.cmp2_sel;
    assign slew_limit_c          = st_r.slew_limit;

endmodule // port_c_upper_pin_mux

`default_nettype wire

// >>> verif/port_c_upper_pin_mux_assertions.sv
// Port-level checker for the upper port C pin multiplexer.
`timescale 1ns/1ps
`default_nettype none

module port_c_upper_pin_mux_checker (
    // Clock, reset and APB.
    input wire logic        clk, resetn, psel, penable, pwrite, pready, pslverr,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata, prdata,
    // Pins.
    input wire logic [2:0]  pin_in, pin_out, pin_oe_n,
    // Peripherals.
    input wire logic        spi_one_enable, spi_one_data_out, pwm3_a_enable, pwm3_output_a,
    input wire logic        pwm3_b_enable, pwm3_output_b, compare3_enable, compare_channel_three,
    input wire logic        serial_tx_active, serial_tx_one, serial_sync_mode, serial_sync_master,
    input wire logic        serial_clk_one, serial_dat_drive, serial_dat_one, serial_rx_one,
    input wire logic        compare3_pin_select
);
    // Shadow copies of direction, latch and analog bits, rebuilt from committed writes.
    logic [2:0] dir_sh;
    logic [2:0] lat_sh;
    logic [2:0] an_sh;
    logic [3:0] quiet;
    wire        wr = psel && penable && pready && pwrite && !pslverr;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dir_sh <= 3'h7;
            lat_sh <= 3'h0;
            an_sh  <= 3'h7;
            quiet  <= 4'h0;
        end else begin
            if (wr && paddr == 8'h10) dir_sh <= pwdata[7:5];
            if (wr && (paddr == 8'h04 || paddr == 8'h08)) lat_sh <= pwdata[7:5];
            if (wr && paddr == 8'h00) an_sh <= pwdata[7:5];
            if (wr || serial_sync_mode) quiet <= 4'h0;
            else if (quiet != 4'hF) quiet <= quiet + 4'h1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    ready_one_cycle_a: assert property ((psel && !penable) |=> pready ##1 !pready)
        else $error("pready is not a single cycle after setup");
    refused_read_a: assert property ((pslverr && !pwrite) |-> pready && prdata == 32'h0)
        else $error("refused read returned data");
    unused_bits_a: assert property ((pready && !pwrite) |-> prdata[31:8] == 24'h0
        && (paddr != 8'h00 || prdata[1:0] == 2'h0) && (paddr != 8'h08 || prdata[4:0] == 5'h0)
        && (paddr != 8'h0C || prdata[7:5] == 3'h0) && (paddr != 8'h14 || !prdata[6]))
        else $error("unimplemented bits read nonzero");
    pin5_drive_a: assert property (pin_oe_n[0] == $past(dir_sh[0]) && (pin_oe_n[0]
        || pin_out[0] == $past(spi_one_enable ? spi_one_data_out : lat_sh[0])))
        else $error("pin 5 drive wrong");
    pin6_output_a: assert property (!$past(dir_sh[1]) |-> !pin_oe_n[1] && pin_out[1] == $past(
        pwm3_a_enable && compare3_pin_select ? pwm3_output_a
        : compare3_enable && compare3_pin_select ? compare_channel_three : lat_sh[1]))
        else $error("pin 6 output priority wrong");
    serial_transmit_a: assert property ($past(dir_sh[1] && serial_tx_active && !serial_sync_mode)
        |-> !pin_oe_n[1] && pin_out[1] == $past(serial_tx_one))
        else $error("pin 6 does not carry transmit data");
    serial_clock_a: assert property ($past(dir_sh[1] && !serial_tx_active) |-> pin_oe_n[1] ==
        !$past(serial_sync_mode && serial_sync_master) && (pin_oe_n[1] || pin_out[1] == $past(serial_clk_one)))
        else $error("pin 6 serial clock wrong");
    pin7_drive_a: assert property ($past(dir_sh[2] && (serial_sync_mode || !serial_dat_drive))
        |-> pin_oe_n[2] == !$past(serial_dat_drive) && (pin_oe_n[2] || pin_out[2] == $past(serial_dat_one)))
        else $error("pin 7 serial data drive wrong");
    pin7_output_a: assert property (!$past(dir_sh[2]) |-> !pin_oe_n[2]
        && pin_out[2] == $past(pwm3_b_enable ? pwm3_output_b : lat_sh[2]))
        else $error("pin 7 output wrong");
    receive_path_a: assert property ((quiet > 4'h4 && dir_sh[2])
        |-> serial_rx_one == ($past(pin_in[2], 3) && !an_sh[2]))
        else $error("receive input does not follow pin 7");
    map_copy_a: assert property ((wr && paddr == 8'h14) |-> ##2 compare3_pin_select == $past(pwdata[2], 2))
        else $error("compare three pin select copy wrong");
endmodule // port_c_upper_pin_mux_checker

bind port_c_upper_pin_mux port_c_upper_pin_mux_checker u_port_c_upper_pin_mux_checker (.*);

`default_nettype wire

// >>> verif/port_c_pin_partner.sv
// Board side of pins 5 to 7: an external driver, and a floating level on released pins.
`timescale 1ns/1ps
`default_nettype none

module port_c_pin_partner (
    input  wire logic       clk,
    input  wire logic [2:0] pin_out,
    input  wire logic [2:0] pin_oe_n,
    input  wire logic [2:0] ext_en,
    input  wire logic [2:0] ext_val,
    output logic      [2:0] pin_in
);
    // A released, undriven pin has no pull, so it wanders instead of keeping its last value.
    logic [2:0] float_r = 3'h5;

    always_ff @(posedge clk) float_r <= ~float_r;

    always_comb begin
        for (int i = 0; i < 3; i++) begin
            pin_in[i] = !pin_oe_n[i] ? pin_out[i] : (ext_en[i] ? ext_val[i] : float_r[i]);
        end
    end
endmodule // port_c_pin_partner

`default_nettype wire

// >>> verif/port_c_upper_pin_mux_bench.sv
// Self-checking bench for the upper port C pin multiplexer.
`timescale 1ns/1ps
`default_nettype none

module port_c_upper_pin_mux_bench;
    import port_c_pkg::*;
    logic        clk, resetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rnd, rd;
    logic [2:0]  pin_in, pin_out, pin_oe_n, ext_en, ext_val;
    logic        spi_one_enable, spi_one_data_out, pwm3_a_enable, pwm3_output_a, pwm3_b_enable, pwm3_output_b;
    logic        compare3_enable, compare_channel_three, serial_tx_active, serial_tx_one, serial_sync_mode;
    logic        serial_sync_master, serial_clk_one, serial_dat_drive, serial_dat_one, compare3_capture_in;
    logic        serial_rx_one, serial_clk_one_in, serial_dat_one_in, pwm2b_pin_select, timer3_clk_pin_select;
    logic        compare3_pin_select, compare2_pin_select, slew_limit_c;
    int          miscompares, n_tests;
    byte_t       offs[5] = '{8'h00, 8'h04, 8'h0C, 8'h10, 8'h14};
    byte_t       masks[5] = '{8'hFC, 8'hFF, 8'h1F, 8'hFF, 8'hBF};
    byte_t       rsts[5] = '{8'hFC, 8'h00, 8'h1F, 8'hFF, 8'hBF};

    port_c_upper_pin_mux u_port_c_upper_pin_mux (.*);
    port_c_pin_partner u_port_c_pin_partner (.*);

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h0);
    endfunction

    task automatic drive(input logic [20:0] v);
        {spi_one_enable, spi_one_data_out, pwm3_a_enable, pwm3_output_a, pwm3_b_enable, pwm3_output_b,
         compare3_enable, compare_channel_three, serial_tx_active, serial_tx_one, serial_sync_mode,
         serial_sync_master, serial_clk_one, serial_dat_drive, serial_dat_one, ext_en, ext_val} <= v;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One APB transfer; read data and the error flag are taken at the edge that sees pready.
    task automatic apb(input logic w, input byte_t a, input logic [31:0] d);
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask

    // Holds reset for the given cycles with idle peripherals, then reads every register except pin level back.
    task automatic reset_check(input int cycles);
        drive(21'h0);
        repeat (cycles) @(posedge clk);
        resetn <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, offs[i], 32'h0);
            chk("reset value", {24'h0, rsts[i]}, rd);
        end
    endtask

    task automatic complete_run;
        if (miscompares == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        complete_run;
    end

    initial begin
        {resetn, psel, penable, pwrite, paddr, pwdata} = '0;
        rnd = 32'hf27cdf38;
        reset_check(12);
        apb(1'b0, 8'h08, 32'h0);
        chk("pin level at reset", 32'h0, rd);
        for (int i = 0; i < 5; i++) begin
            rnd = lfsr(rnd);
            apb(1'b1, offs[i], rnd);
            apb(1'b0, offs[i], 32'h0);
            chk("readback", {24'h0, rnd[7:0] & masks[i]}, rd);
        end
        apb(1'b1, 8'h08, 32'h5A);
        apb(1'b0, 8'h04, 32'h0);
        chk("latch via pin level", 32'h5A, rd);
        apb(1'b1, 8'h18, 32'h1);
        chk("unmapped write error", 32'h1, {31'h0, err});
        apb(1'b0, 8'h18, 32'h0);
        chk("unmapped read", 32'h1, {rd[30:0], err});
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, 8'h0C, k ? 32'h04 : 32'h1B);
            apb(1'b1, 8'h14, k ? 32'hBF : 32'h0);
            repeat (2) @(posedge clk);
            chk("pin map", k ? 32'hF : 32'h0, {pwm2b_pin_select, timer3_clk_pin_select,
                compare3_pin_select, compare2_pin_select});
            chk("slew limit", k, {31'h0, slew_limit_c});
        end
        apb(1'b1, 8'h10, 32'hFF);
        for (int k = 0; k < 4; k++) begin
            rnd = lfsr(rnd);
            apb(1'b1, 8'h00, k[0] ? 32'hE0 : 32'h0);
            drive({10'h0, k[1], 7'h7, rnd[2:0]});
            repeat (5) @(posedge clk);
            apb(1'b0, 8'h08, 32'h0);
            chk("pin level", k[0] ? 32'h0 : {24'h0, rnd[2:0], 5'h0}, rd);
            chk("capture input", {31'h0, !k[0] && rnd[1]}, {31'h0, compare3_capture_in});
            chk("receive input", {31'h0, !k[0] && rnd[2]}, {31'h0, serial_rx_one});
            chk("clock input", {31'h0, k[1] && !k[0] && rnd[1]}, {31'h0, serial_clk_one_in});
            chk("data input", {31'h0, k[1] && !k[0] && rnd[2]}, {31'h0, serial_dat_one_in});
        end
        rnd = lfsr(rnd);
        drive(21'h0);
        apb(1'b1, 8'h04, rnd);
        apb(1'b1, 8'h00, 32'hFC);
        apb(1'b1, 8'h10, 32'h0);
        repeat (3) @(posedge clk);
        chk("latch drive", {26'h0, 3'h0, rnd[7:5]}, {26'h0, pin_oe_n, pin_out});
        drive({1'b1, !rnd[5], 19'h0});
        repeat (2) @(posedge clk);
        chk("spi data out", {31'h0, !rnd[5]}, {31'h0, pin_out[0]});
        for (int i = 0; i < 60; i++) begin
            rnd = lfsr(rnd);
            apb(1'b1, offs[int'(rnd[26:24]) % 5], {24'h0, rnd[15:8]});
            repeat (8) begin
                @(posedge clk);
                rnd = lfsr(rnd);
                drive(rnd[20:0]);
            end
        end
        @(posedge clk);
        resetn <= 1'b0;
        reset_check(3);
        complete_run;
    end
endmodule // port_c_upper_pin_mux_bench

`default_nettype wire
